/* File: src/psta_pkg.sv */
// Constants and types shared by the program space table access block
package psta_pkg;
    localparam int PSTA_WORD_W = 24;
    localparam int PSTA_DATA_W = 16;
    localparam int PSTA_PAGE_W = 8;
    localparam int PSTA_EA_W = 16;
    localparam int PSTA_ADDR_W = 24;
    localparam int PSTA_IDX_W = 23;
    localparam int PSTA_CFG_BIT = 7;
    localparam logic [23:0] PSTA_RESET_VECTOR = 24'h000000;
    localparam logic [23:0] PSTA_VECTOR_END = 24'h000200;
    localparam logic [23:0] PSTA_PC_STEP = 24'h000002;
    localparam logic [7:0] PSTA_PAGE_RESET = 8'h00;
    localparam logic [15:0] PSTA_DATA_ZERO = 16'h0000;
    localparam logic [7:0] PSTA_BYTE_ZERO = 8'h00;
    localparam logic [2:0] PSTA_BE_NONE = 3'h0;
    localparam logic [2:0] PSTA_BE_LOW_WORD = 3'h3;
    localparam logic [2:0] PSTA_BE_LOW_BYTE = 3'h1;
    localparam logic [2:0] PSTA_BE_MID_BYTE = 3'h2;
    localparam logic [2:0] PSTA_BE_HIGH_BYTE = 3'h4;

    typedef enum logic [1:0] {
        PSTA_RD_LOW,
        PSTA_RD_HIGH,
        PSTA_WR_LOW,
        PSTA_WR_HIGH
    } psta_op_t;
endpackage : psta_pkg

/* File: src/psta_lane_mux.sv */
// Read lane steering from a 24-bit program word onto the 16-bit data path
`timescale 1ns/1ps
module psta_lane_mux
    import psta_pkg::*;
(
    // Program word and access form
    input wire logic [PSTA_WORD_W-1:0] word,
    input wire logic high,
    input wire logic byte_mode,
    input wire logic byte_sel,
    // Steered data
    output logic [PSTA_DATA_W-1:0] data
);
    // Select word space and byte lane
    always_comb begin
        data = PSTA_DATA_ZERO;
        if (!high) begin
            if (!byte_mode) begin
                data = word[15:0];
            end else if (byte_sel) begin
                data = {PSTA_BYTE_ZERO, word[15:8]};
            end else begin
                data = {PSTA_BYTE_ZERO, word[7:0]};
            end
        end else begin
            if (!byte_mode) begin
                data = {PSTA_BYTE_ZERO, word[23:16]};
            end else if (byte_sel) begin
                data = PSTA_DATA_ZERO;
            end else begin
                data = {PSTA_BYTE_ZERO, word[23:16]};
            end
        end
    end
endmodule : psta_lane_mux

/* File: src/psta_table_access.sv */
// Program space table access: page register, table read/write steering, program counter
// How it works
// - Program location is 24 bits: lower 16-bit word plus upper word with empty top byte.
// - Lower and upper word share one address; the operation picks the word, address bit 0 the byte.
// - Program counter steps by two per 24-bit location, aligned to the lower word.
// - Addresses 0x000000 up to 0x0001FF are reserved for fixed execution vectors.
// - Read low, word form, returns program bits 15:0 as data bits 15:0.
// - Read low, byte form, returns upper byte if selector is 1, else lower.
// - Read high, word form, returns bits 23:16 low, phantom byte forced zero.
// - Read high, byte form, returns selected upper byte; phantom byte reads zero.
// - Only high operations read or write the upper 8 program bits.
// - Two 16-bit spaces share addresses: low ops lower word, high ops upper byte.
// - Every table operation has a byte form and a word form.
// - Write low targets the lower word, write high the upper byte.
// - Page register gives upper address; its bit 7 selects configuration space.
// - Lower word reads reach any program address directly, no data window.
`timescale 1ns/1ps
module psta_table_access
    import psta_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Table operation request from the core
    input wire logic tbl_valid,
    input wire psta_op_t tbl_op,
    input wire logic tbl_byte,
    input wire logic [PSTA_EA_W-1:0] tbl_ea,
    input wire logic [PSTA_DATA_W-1:0] tbl_wdata,
    // Table page register access
    input wire logic page_we,
    input wire logic [PSTA_PAGE_W-1:0] page_wdata,
    output logic [PSTA_PAGE_W-1:0] table_page_register,
    // Read result to the core
    output logic rd_valid,
    output logic [PSTA_DATA_W-1:0] rd_data,
    // Program memory port
    output logic mem_re,
    output logic mem_we,
    output logic [PSTA_IDX_W-1:0] mem_addr,
    output logic mem_cfg,
    output logic [2:0] mem_wbe,
    output logic [PSTA_WORD_W-1:0] mem_wdata,
    input wire logic [PSTA_WORD_W-1:0] mem_rdata,
    // Table target falls inside the vector region
    output logic tbl_in_vectors,
    // Program counter
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [PSTA_ADDR_W-1:0] pc_target,
    output logic [PSTA_ADDR_W-1:0] pc,
    output logic pc_in_vectors
);
    logic [PSTA_PAGE_W-1:0] next_page;
    logic [PSTA_ADDR_W-1:0] next_pc;
    logic next_pc_in_vectors;
    logic next_mem_re;
    logic next_mem_we;
    logic [PSTA_IDX_W-1:0] next_mem_addr;
    logic next_mem_cfg;
    logic [2:0] next_mem_wbe;
    logic [PSTA_WORD_W-1:0] next_mem_wdata;
    logic next_in_vectors;
    logic rd_high;
    logic rd_byte;
    logic rd_sel;
    logic next_rd_high;
    logic next_rd_byte;
    logic next_rd_sel;
    logic next_rd_valid;
    logic [PSTA_DATA_W-1:0] next_rd_data;
    logic [PSTA_DATA_W-1:0] lane_data;
    logic [PSTA_ADDR_W-1:0] tbl_addr;

    // True when a program address lies in the reserved vector area
    function automatic logic psta_in_vectors(input logic [PSTA_ADDR_W-1:0] addr);
        return addr < PSTA_VECTOR_END;
    endfunction : psta_in_vectors

    // Full program address from page and effective address
    assign tbl_addr = {table_page_register, tbl_ea};

    // Page register update
    always_comb begin
        next_page = table_page_register;
        if (page_we) begin
            next_page = page_wdata;
        end
    end

    // Program counter: load wins over step, always lower-word aligned
    always_comb begin
        next_pc = pc;
        if (pc_load) begin
            next_pc = {pc_target[PSTA_ADDR_W-1:1], 1'b0};
        end else if (pc_step) begin
            next_pc = pc + PSTA_PC_STEP;
        end
        next_pc_in_vectors = psta_in_vectors(next_pc);
    end

    // Request decode into the memory port stage
    always_comb begin
        next_mem_re = 1'b0;
        next_mem_we = 1'b0;
        next_mem_addr = mem_addr;
        next_mem_cfg = mem_cfg;
        next_mem_wbe = PSTA_BE_NONE;
        next_mem_wdata = mem_wdata;
        next_in_vectors = tbl_in_vectors;
        next_rd_high = rd_high;
        next_rd_byte = rd_byte;
        next_rd_sel = rd_sel;
        if (tbl_valid) begin
            // Both word spaces share one index; odd byte of EA is the lane
            next_mem_addr = tbl_addr[PSTA_ADDR_W-1:1];
            next_mem_cfg = table_page_register[PSTA_CFG_BIT];
            next_in_vectors = !table_page_register[PSTA_CFG_BIT] && psta_in_vectors(tbl_addr);
            next_rd_high = (tbl_op == PSTA_RD_HIGH);
            next_rd_byte = tbl_byte;
            next_rd_sel = tbl_ea[0];
            next_mem_wdata = {tbl_wdata[7:0], tbl_wdata};
            unique case (tbl_op)
                PSTA_RD_LOW, PSTA_RD_HIGH: begin
                    next_mem_re = 1'b1;
                end
                PSTA_WR_LOW: begin
                    // Lower word space only, upper byte untouched
                    next_mem_we = 1'b1;
                    if (!tbl_byte) begin
                        next_mem_wbe = PSTA_BE_LOW_WORD;
                    end else if (tbl_ea[0]) begin
                        next_mem_wbe = PSTA_BE_MID_BYTE;
                        next_mem_wdata = {tbl_wdata[7:0], tbl_wdata[7:0], tbl_wdata[7:0]};
                    end else begin
                        next_mem_wbe = PSTA_BE_LOW_BYTE;
                    end
                end
                PSTA_WR_HIGH: begin
                    // Phantom byte write stores nothing
                    next_mem_we = 1'b1;
                    if (!tbl_byte || !tbl_ea[0]) begin
                        next_mem_wbe = PSTA_BE_HIGH_BYTE;
                    end
                end
            endcase
        end
    end

    // Lane steering of the returned program word
    psta_lane_mux u_lane (
        .word(mem_rdata),
        .high(rd_high),
        .byte_mode(rd_byte),
        .byte_sel(rd_sel),
        .data(lane_data)
    );

    // Read result stage
    always_comb begin
        next_rd_valid = mem_re;
        next_rd_data = rd_data;
        if (mem_re) begin
            next_rd_data = lane_data;
        end
    end

    // Registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            table_page_register <= PSTA_PAGE_RESET;
            pc <= PSTA_RESET_VECTOR;
            mem_re <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_cfg <= 1'b0;
            mem_wbe <= PSTA_BE_NONE;
            mem_wdata <= '0;
            tbl_in_vectors <= 1'b0;
            rd_high <= 1'b0;
            rd_byte <= 1'b0;
            rd_sel <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= PSTA_DATA_ZERO;
            pc_in_vectors <= 1'b1;
        end else begin
            table_page_register <= next_page;
            pc <= next_pc;
            mem_re <= next_mem_re;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_cfg <= next_mem_cfg;
            mem_wbe <= next_mem_wbe;
            mem_wdata <= next_mem_wdata;
            tbl_in_vectors <= next_in_vectors;
            rd_high <= next_rd_high;
            rd_byte <= next_rd_byte;
            rd_sel <= next_rd_sel;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            pc_in_vectors <= next_pc_in_vectors;
        end
    end
endmodule : psta_table_access

/* File: verif/psta_properties.sv */
// Concurrent checks on the table access ports
`timescale 1ns/1ps
module psta_properties
    import psta_pkg::*;
(
    // Clock, reset and request
    input wire logic mclk,
    input wire logic resetn,
    input wire logic tbl_valid,
    input wire psta_op_t tbl_op,
    input wire logic tbl_byte,
    input wire logic [PSTA_EA_W-1:0] tbl_ea,
    // Page, read result and memory port
    input wire logic [PSTA_PAGE_W-1:0] table_page_register,
    input wire logic rd_valid,
    input wire logic [PSTA_DATA_W-1:0] rd_data,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [PSTA_IDX_W-1:0] mem_addr,
    input wire logic mem_cfg,
    input wire logic [2:0] mem_wbe,
    input wire logic [PSTA_WORD_W-1:0] mem_rdata,
    // Program counter
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [PSTA_ADDR_W-1:0] pc_target,
    input wire logic [PSTA_ADDR_W-1:0] pc,
    input wire logic pc_in_vectors
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Request is one of the two reads
    wire rd_req = tbl_valid && (tbl_op == PSTA_RD_LOW || tbl_op == PSTA_RD_HIGH);
    rd_latency_a: assert property (rd_req |=> mem_re ##1 rd_valid)
        else $error("read answer late");
    wr_latency_a: assert property (tbl_valid && !rd_req |=> mem_we && !mem_re)
        else $error("write strobe missing");
    low_word_a: assert property (tbl_valid && tbl_op == PSTA_RD_LOW && !tbl_byte ##1 1'b1 |=>
        rd_data == $past(mem_rdata[15:0])) else $error("low word data wrong");
    high_zero_a: assert property (tbl_valid && tbl_op == PSTA_RD_HIGH |-> ##2 rd_data[15:8] == 8'h00)
        else $error("phantom byte not zero");
    phantom_read_a: assert property (tbl_valid && tbl_op == PSTA_RD_HIGH && tbl_byte && tbl_ea[0] |-> ##2
        rd_data == PSTA_DATA_ZERO) else $error("phantom byte read not zero");
    low_lanes_a: assert property (tbl_valid && tbl_op == PSTA_WR_LOW |=>
        !mem_wbe[2] && mem_wbe != PSTA_BE_NONE) else $error("low write lanes wrong");
    byte_lane_a: assert property (tbl_valid && tbl_op == PSTA_WR_LOW && tbl_byte |=>
        mem_wbe == ($past(tbl_ea[0]) ? PSTA_BE_MID_BYTE : PSTA_BE_LOW_BYTE)) else $error("byte lane wrong");
    table_addr_a: assert property (tbl_valid |=>
        mem_addr == {$past(table_page_register), $past(tbl_ea[15:1])}
        && mem_cfg == $past(table_page_register[7])) else $error("table address wrong");
    pc_step_a: assert property (pc_step && !pc_load |=> pc == $past(pc) + PSTA_PC_STEP)
        else $error("pc step wrong");
    pc_load_a: assert property (pc_load |=> pc == {$past(pc_target[23:1]), 1'b0})
        else $error("pc load wrong");
    pc_vector_a: assert property (pc_in_vectors == (pc < PSTA_VECTOR_END))
        else $error("pc vector flag wrong");
    // Main scenarios
    cover property (rd_req ##1 rd_req);
    cover property (pc_load);
    cover property (tbl_valid && table_page_register[7]);
    cover property (tbl_valid && tbl_op == PSTA_WR_HIGH ##1 rd_req);
endmodule : psta_properties

/* File: verif/psta_mem_model.sv */
// Behavioural program memory behind the table port
`timescale 1ns/1ps
module psta_mem_model
    import psta_pkg::*;
(
    // Memory port
    input wire logic mclk,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [PSTA_IDX_W-1:0] mem_addr,
    input wire logic mem_cfg,
    input wire logic [2:0] mem_wbe,
    input wire logic [PSTA_WORD_W-1:0] mem_wdata,
    output logic [PSTA_WORD_W-1:0] mem_rdata
);
    logic [PSTA_WORD_W-1:0] mem [64]; // 24-bit locations
    wire [5:0] idx = {mem_cfg, mem_addr[4:0]}; // Config half above user half
    // Known start contents
    initial for (int i = 0; i < 64; i++) mem[i] = {8'(i * 5 + 1), 8'(i ^ 8'ha5), 8'(i + 8'h30)};
    // Data only while read strobe is high, inverted otherwise
    assign mem_rdata = mem_re ? mem[idx] : ~mem[idx];
    // Lane writes
    always @(posedge mclk) begin
        if (mem_we) begin
            for (int l = 0; l < 3; l++) if (mem_wbe[l]) mem[idx][l*8+:8] <= mem_wdata[l*8+:8];
        end
    end
endmodule : psta_mem_model

/* File: verif/tb.sv */
// Self-checking bench for the table access block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb
    import psta_pkg::*;
;
    logic mclk = 1'b0, resetn = 1'b0, tbl_valid = 1'b0, tbl_byte = 1'b0, page_we = 1'b0, pc_step = 1'b0;
    logic pc_load = 1'b0, vec_exp = 1'b0;
    psta_op_t tbl_op = PSTA_RD_LOW;
    logic [15:0] tbl_ea = '0, tbl_wdata = '0, rd_data, e_rd;
    logic [7:0] page_wdata = '0, page = '0, table_page_register;
    logic [23:0] pc_target = '0, exp_pc = '0, mem_wdata, mem_rdata, pc, sh [64];
    logic [22:0] mem_addr;
    logic [2:0] mem_wbe;
    logic [5:0] k;
    logic rd_valid, mem_re, mem_we, mem_cfg, tbl_in_vectors, pc_in_vectors;
    logic [31:0] rs = 32'he3b789d0;
    logic [15:0] q [$];
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    psta_table_access u_psta_table_access (
        .mclk(mclk), .resetn(resetn),
        .tbl_valid(tbl_valid), .tbl_op(tbl_op), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata),
        .page_we(page_we), .page_wdata(page_wdata), .table_page_register(table_page_register),
        .rd_valid(rd_valid), .rd_data(rd_data),
        .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr), .mem_cfg(mem_cfg), .mem_wbe(mem_wbe),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .tbl_in_vectors(tbl_in_vectors),
        .pc_step(pc_step), .pc_load(pc_load), .pc_target(pc_target), .pc(pc), .pc_in_vectors(pc_in_vectors)
    );
    psta_mem_model u_psta_mem_model (
        .mclk(mclk), .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr), .mem_cfg(mem_cfg),
        .mem_wbe(mem_wbe), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
    );
    // Clock and cycle ceiling
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            close_out();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    // Expected read value for one location
    function automatic logic [15:0] rexp(psta_op_t o, logic b, logic a0, logic [23:0] w);
        if (o == PSTA_RD_LOW) return b ? {8'h00, a0 ? w[15:8] : w[7:0]} : w[15:0];
        return (b && a0) ? 16'h0000 : {8'h00, w[23:16]};
    endfunction : rexp
    task close_out;
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Read results against the oldest note
    always @(negedge mclk) if (rd_valid === 1'b1) begin
        e_rd = q.pop_front();
        `CHK("rd_data", e_rd, rd_data)
    end
    // Random mixed traffic, page and pc activity
    initial begin
        for (int i = 0; i < 64; i++) sh[i] = {8'(i * 5 + 1), 8'(i ^ 8'ha5), 8'(i + 8'h30)};
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        `CHK("pc_reset", PSTA_RESET_VECTOR, pc)
        for (int n = 0; n < 600; n++) begin
            rs = xs(rs);
            tbl_valid = rs[0];
            tbl_op = psta_op_t'(rs[2:1]);
            tbl_byte = rs[3];
            tbl_ea = {rs[4] ? 6'h00 : rs[31:26], rs[25:16]};
            tbl_wdata = rs[15:0] ^ rs[31:16];
            page_we = rs[10] & rs[11];
            page_wdata = rs[12] ? 8'h00 : (rs[31:24] ^ rs[7:0]);
            pc_step = rs[5];
            pc_load = rs[6] & rs[7];
            pc_target = {rs[8] ? 14'h0000 : rs[31:18], rs[17:8]};
            if (tbl_valid) begin
                k = {page[7], tbl_ea[5:1]};
                vec_exp = !page[7] && {page, tbl_ea} < PSTA_VECTOR_END;
                if (tbl_op == PSTA_RD_LOW || tbl_op == PSTA_RD_HIGH)
                    q.push_back(rexp(tbl_op, tbl_byte, tbl_ea[0], sh[k]));
                else if (tbl_op == PSTA_WR_LOW && !tbl_byte) sh[k][15:0] = tbl_wdata;
                else if (tbl_op == PSTA_WR_LOW) sh[k][tbl_ea[0]*8+:8] = tbl_wdata[7:0];
                else if (!(tbl_byte && tbl_ea[0])) sh[k][23:16] = tbl_wdata[7:0];
            end
            if (page_we) page = page_wdata;
            exp_pc = pc_load ? {pc_target[23:1], 1'b0} : pc_step ? exp_pc + PSTA_PC_STEP : exp_pc;
            @(negedge mclk);
            `CHK("pc", exp_pc, pc)
            `CHK("pc_in_vectors", exp_pc < PSTA_VECTOR_END, pc_in_vectors)
            `CHK("page", page, table_page_register)
            if (tbl_valid) `CHK("tbl_in_vectors", vec_exp, tbl_in_vectors)
        end
        tbl_valid = 1'b0;
        page_we = 1'b0;
        pc_step = 1'b0;
        pc_load = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("reads_left", 0, q.size())
        close_out();
    end
endmodule : tb
bind psta_table_access psta_properties u_psta_properties (
    .mclk(mclk), .resetn(resetn), .tbl_valid(tbl_valid), .tbl_op(tbl_op), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea),
    .table_page_register(table_page_register), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr), .mem_cfg(mem_cfg), .mem_wbe(mem_wbe),
    .mem_rdata(mem_rdata), .pc_step(pc_step), .pc_load(pc_load), .pc_target(pc_target), .pc(pc),
    .pc_in_vectors(pc_in_vectors)
);
